// ==== rtl/ccp_clock_config.sv ====
// Purpose: upper fields of the clock configuration register and the dividers they steer
// Assumes: source clocks arrive as levels synchronous to clk and slower than clk/2
// Notes: derived clocks are rebuilt from sampled edges, so they jitter by one clk period
//
// Operation
// - pll_multiplier at 21:18: codes 0..14 give x2..x16, code 15 also x16.
// - pll_multiplier writes are ignored while the pll is enabled.
// - pll_ext_osc_predivider writes are ignored while the pll is enabled.
// - bit 17: 0 takes the external oscillator undivided, 1 halves it.
// - usb_clock_divider 23:22 divides pll output by 1.5, 1, 2, 2.5.
// - while either usb device clock is enabled the usb divider cannot be cleared.
// - clock_out_select 26:24: 0xx none, system, rc, external, pll halved.
// - switching the output source may truncate a pulse; no glitch-free switch.
// - bit 27: fpu clock is bus clock undivided for 0, halved for 1.
// - sdram_clock_divider 29:28: 00 undivided, 01 by 2, else by 4.
module ccp_clock_config
  import ccp_pkg::*;
(
  input wire logic clk, // 125 MHz block clock
  input wire logic reset, // synchronous, active high
  input wire logic [CCP_ADDR_W-1:0] reg_addr, // byte address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after the strobe
  input wire logic pll_enabled, // pll is running
  input wire logic usb_device1_clk_en, // usb device 1 clock enabled
  input wire logic usb_device2_clk_en, // usb device 2 clock enabled
  input wire logic system_clock, // system clock level
  input wire logic internal_rc_clock, // internal rc clock level
  input wire logic external_osc_clock, // external oscillator level
  input wire logic pll_output_clock, // pll output level
  input wire logic bus_clock, // bus clock level
  input wire logic memory_controller_clock, // memory controller clock level
  output ccp_cfg_t cfg, // current field values
  output logic [4:0] pll_multiple, // decoded pll multiple, 2..16
  output logic usb_clock, // usb device clock
  output logic clock_output_pin, // clock output pin level
  output logic fpu_clock, // fpu clock
  output logic sdram_clock // sdram clock
);

  // advance a half-period divider on each source edge; high for the first half, rounded up
  function automatic ccp_div_t div_step(input ccp_div_t cur, input logic edge_seen,
                                        input logic [3:0] period);
    ccp_div_t nxt;
    logic [3:0] cnt_up;
    nxt = cur;
    cnt_up = cur.cnt + 4'h1;
    if (edge_seen) begin
      nxt.cnt = (cnt_up >= period) ? 4'h0 : cnt_up;
      nxt.level = nxt.cnt < ((period + 4'h1) >> 1);
    end
    return nxt;
  endfunction

  // half-periods of the pll output per usb clock period; fractional codes give uneven duty
  function automatic logic [3:0] usb_half_periods(input logic [1:0] code);
    logic [3:0] p;
    case (code)
      2'h0: p = CCP_HP_DIV1P5;
      2'h1: p = CCP_HP_DIV1;
      2'h2: p = CCP_HP_DIV2;
      default: p = CCP_HP_DIV2P5;
    endcase
    return p;
  endfunction

  // half-periods of the memory controller clock per sdram clock period
  function automatic logic [3:0] sdram_half_periods(input logic [1:0] code);
    logic [3:0] p;
    case (code)
      2'h0: p = CCP_HP_DIV1;
      2'h1: p = CCP_HP_DIV2;
      default: p = CCP_HP_DIV4;
    endcase
    return p;
  endfunction

  function automatic logic [4:0] mult_of(input logic [3:0] code);
    logic [4:0] m;
    m = (code == CCP_MULT_TOP_CODE) ? CCP_MULT_MAX : ({1'b0, code} + CCP_MULT_BASE);
    return m;
  endfunction

  function automatic logic [31:0] cfg_word(input ccp_cfg_t c);
    logic [31:0] w;
    w = 32'h00000000;
    w[CCP_PREDIV_POS] = c.pll_ext_osc_predivider;
    w[CCP_MULT_POS +: 4] = c.pll_multiplier;
    w[CCP_USB_POS +: 2] = c.usb_clock_divider;
    w[CCP_OUTSEL_POS +: 3] = c.clock_out_select;
    w[CCP_FPU_POS] = c.fpu_clock_divider;
    w[CCP_SDRAM_POS +: 2] = c.sdram_clock_divider;
    return w;
  endfunction

  // register port decode
  wire logic cfg_hit = reg_addr == CCP_CFG_OFFSET;
  wire logic cfg_write = reg_wr && cfg_hit;
  wire logic cfg_read = reg_rd && cfg_hit;
  wire logic usb_clk_on = usb_device1_clk_en || usb_device2_clk_en;

  wire logic [3:0] wr_mult = reg_wdata[CCP_MULT_POS +: 4];
  wire logic [1:0] wr_usb = reg_wdata[CCP_USB_POS +: 2];

  // a running usb clock lets bits be set but never cleared
  // the write is merged, not refused, so a read shows old bits or'ed with new ones
  wire logic [1:0] usb_field_new = usb_clk_on ? (cfg.usb_clock_divider | wr_usb) : wr_usb;

  ccp_cfg_t next_cfg;
  always_comb begin
    next_cfg = cfg;
    if (cfg_write) begin
      if (!pll_enabled) begin
        next_cfg.pll_multiplier = wr_mult;
        next_cfg.pll_ext_osc_predivider = reg_wdata[CCP_PREDIV_POS];
      end
      next_cfg.usb_clock_divider = usb_field_new;
      next_cfg.clock_out_select = reg_wdata[CCP_OUTSEL_POS +: 3];
      next_cfg.fpu_clock_divider = reg_wdata[CCP_FPU_POS];
      next_cfg.sdram_clock_divider = reg_wdata[CCP_SDRAM_POS +: 2];
    end
  end

  wire logic [31:0] next_rdata = cfg_read ? cfg_word(cfg) : 32'h00000000;

  // sampled history of the pll, bus and memory controller sources, for edge detection
  // history resets low: a source that is high at release counts one edge, a harmless slip
  logic pll_prev;
  logic bus_prev;
  logic mem_prev;
  wire logic pll_edge = pll_output_clock != pll_prev;
  wire logic bus_edge = bus_clock != bus_prev;
  wire logic mem_edge = memory_controller_clock != mem_prev;

  // period selection per field
  // a divider change takes effect on the next source edge; the count is not restarted,
  // so the first period after a change may be short
  wire logic [3:0] usb_period = usb_half_periods(cfg.usb_clock_divider);
  wire logic [3:0] fpu_period = cfg.fpu_clock_divider ? CCP_HP_DIV2 : CCP_HP_DIV1;
  wire logic [3:0] sdram_period = sdram_half_periods(cfg.sdram_clock_divider);

  ccp_div_t usb_div;
  ccp_div_t fpu_div;
  ccp_div_t sdram_div;
  ccp_div_t pll_half_div;
  wire ccp_div_t next_usb_div = div_step(usb_div, pll_edge, usb_period);
  wire ccp_div_t next_fpu_div = div_step(fpu_div, bus_edge, fpu_period);
  wire ccp_div_t next_sdram_div = div_step(sdram_div, mem_edge, sdram_period);
  wire ccp_div_t next_pll_half_div = div_step(pll_half_div, pll_edge, CCP_HP_DIV2);

  // output pin source; the mux switches at once, so a short pulse is possible
  // glitch-free switching would need handshakes in every source domain, not worth it here
  logic next_clock_out;
  always_comb begin
    case (cfg.clock_out_select)
      CCP_OUT_SYS: next_clock_out = system_clock;
      CCP_OUT_RC: next_clock_out = internal_rc_clock;
      CCP_OUT_EXT: next_clock_out = external_osc_clock;
      CCP_OUT_PLL_HALF: next_clock_out = next_pll_half_div.level;
      default: next_clock_out = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg <= CCP_CFG_ZERO;
      reg_rdata <= CCP_CFG_RESET;
      pll_multiple <= CCP_MULT_BASE;
    end else begin
      cfg <= next_cfg;
      reg_rdata <= next_rdata;
      pll_multiple <= mult_of(next_cfg.pll_multiplier);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pll_prev <= 1'b0;
      bus_prev <= 1'b0;
      mem_prev <= 1'b0;
      usb_div <= CCP_DIV_ZERO;
      fpu_div <= CCP_DIV_ZERO;
      sdram_div <= CCP_DIV_ZERO;
      pll_half_div <= CCP_DIV_ZERO;
    end else begin
      pll_prev <= pll_output_clock;
      bus_prev <= bus_clock;
      mem_prev <= memory_controller_clock;
      usb_div <= next_usb_div;
      fpu_div <= next_fpu_div;
      sdram_div <= next_sdram_div;
      pll_half_div <= next_pll_half_div;
    end
  end

  // every derived clock is a flop, so the pin never sees a combinational glitch
  always_ff @(posedge clk) begin
    if (reset) begin
      usb_clock <= 1'b0;
      fpu_clock <= 1'b0;
      sdram_clock <= 1'b0;
      clock_output_pin <= 1'b0;
    end else begin
      usb_clock <= next_usb_div.level;
      fpu_clock <= next_fpu_div.level;
      sdram_clock <= next_sdram_div.level;
      clock_output_pin <= next_clock_out;
    end
  end

endmodule

// ==== rtl/ccp_pkg.sv ====
// Purpose: shared constants and types of the clock configuration prescaler block
// Assumes: one 32-bit register at a byte offset, plain register port
// Notes: only bits 31:17 belong to this block; bits 16:0 read as zero here
package ccp_pkg;
  localparam int CCP_ADDR_W = 8;
  localparam logic [CCP_ADDR_W-1:0] CCP_CFG_OFFSET = 8'h04;
  localparam logic [31:0] CCP_CFG_RESET = 32'h00000000;

  localparam int CCP_PREDIV_POS = 17;
  localparam int CCP_MULT_POS = 18;
  localparam int CCP_USB_POS = 22;
  localparam int CCP_OUTSEL_POS = 24;
  localparam int CCP_FPU_POS = 27;
  localparam int CCP_SDRAM_POS = 28;

  localparam logic [3:0] CCP_MULT_TOP_CODE = 4'hf;
  localparam logic [4:0] CCP_MULT_BASE = 5'h02;
  localparam logic [4:0] CCP_MULT_MAX = 5'h10;

  // divider periods counted in half-periods of the source
  localparam logic [3:0] CCP_HP_DIV1 = 4'h2;
  localparam logic [3:0] CCP_HP_DIV1P5 = 4'h3;
  localparam logic [3:0] CCP_HP_DIV2 = 4'h4;
  localparam logic [3:0] CCP_HP_DIV2P5 = 4'h5;
  localparam logic [3:0] CCP_HP_DIV4 = 4'h8;

  typedef enum logic [2:0] {
    CCP_OUT_NONE = 3'b000,
    CCP_OUT_SYS = 3'b100,
    CCP_OUT_RC = 3'b101,
    CCP_OUT_EXT = 3'b110,
    CCP_OUT_PLL_HALF = 3'b111
  } ccp_out_sel_t;

  typedef struct packed {
    logic [1:0] sdram_clock_divider;
    logic fpu_clock_divider;
    logic [2:0] clock_out_select;
    logic [1:0] usb_clock_divider;
    logic [3:0] pll_multiplier;
    logic pll_ext_osc_predivider;
  } ccp_cfg_t;

  localparam ccp_cfg_t CCP_CFG_ZERO = ccp_cfg_t'(13'h0000);

  typedef struct packed {
    logic [3:0] cnt;
    logic level;
  } ccp_div_t;

  localparam ccp_div_t CCP_DIV_ZERO = ccp_div_t'(5'h00);
endpackage

// ==== tb/ccp_clock_config_checker.sv ====
// Purpose: property checks on the clock configuration block ports
// Assumes: source clocks change no faster than once per 2 clk
// Notes: bound to every instance of ccp_clock_config
module ccp_checker
  import ccp_pkg::*;
(
  input wire logic clk, // clock
  input wire logic reset, // sync reset
  input wire logic reg_wr, // write strobe
  input wire logic [31:0] reg_rdata, // read data
  input wire logic pll_enabled, // pll running
  input wire logic usb_device1_clk_en, // usb 1 enable
  input wire logic usb_device2_clk_en, // usb 2 enable
  input wire logic system_clock, // source
  input wire logic internal_rc_clock, // source
  input wire logic external_osc_clock, // source
  input wire ccp_cfg_t cfg, // fields
  input wire logic [4:0] pll_multiple, // multiple
  input wire logic clock_output_pin, // pin
  input wire logic sdram_clock // sdram clock
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire logic [2:0] sel = cfg.clock_out_select;
  wire logic pin_src = sel[0] ? internal_rc_clock : (sel[1] ? external_osc_clock : system_clock);
  sequence s_wr_locked; reg_wr && pll_enabled; endsequence
  sequence s_usb_held; reg_wr && (usb_device1_clk_en || usb_device2_clk_en); endsequence
  chk_rsvd_zero: assert property (reg_rdata[31:30] == 2'b00)
    else $error("reserved bits read nonzero");
  chk_mult_decode: assert property (pll_multiple == ((cfg.pll_multiplier == 4'hf) ? 5'h10 :
    {1'b0, cfg.pll_multiplier} + 5'h02)) else $error("pll multiple wrong");
  chk_mult_lock: assert property (s_wr_locked |=> $stable(cfg.pll_multiplier))
    else $error("multiplier changed while pll runs");
  chk_prediv_lock: assert property (s_wr_locked |=> $stable(cfg.pll_ext_osc_predivider))
    else $error("predivider changed while pll runs");
  chk_usb_noclear: assert property (s_usb_held |=>
    (cfg.usb_clock_divider & $past(cfg.usb_clock_divider)) == $past(cfg.usb_clock_divider))
    else $error("usb divider bit cleared");
  chk_pin_quiet: assert property ((!sel[2]) [*2] |-> !clock_output_pin)
    else $error("pin active with no source");
  chk_pin_follow: assert property ((sel[2] && sel != 3'b111) [*2] |->
    clock_output_pin == $past(pin_src)) else $error("pin does not follow source");
  chk_sdram_slow: assert property ((cfg.sdram_clock_divider[1]) [*3] ##0 $changed(sdram_clock)
    |=> $stable(sdram_clock) [*2]) else $error("sdram clock too fast for divide by 4");
endmodule

bind ccp_clock_config ccp_checker chk_i (.clk, .reset, .reg_wr, .reg_rdata, .pll_enabled,
  .usb_device1_clk_en, .usb_device2_clk_en, .system_clock, .internal_rc_clock,
  .external_osc_clock, .cfg, .pll_multiple, .clock_output_pin, .sdram_clock);

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for ccp_clock_config
// Assumes: every source clock shares one waveform toggling every 3 clk
// Notes: derived rates judged by toggle counts, allowing a phase slip of 2
module tb_top
  import ccp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, pll_enabled = 0, usb1 = 0, usb2 = 0;
  logic src = 0, rd_d = 0;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  wire logic [31:0] reg_rdata;
  wire logic [4:0] pll_multiple;
  wire logic usb_clock, clock_output_pin, fpu_clock, sdram_clock;
  wire logic [3:0] outs = {usb_clock, fpu_clock, sdram_clock, clock_output_pin};
  int err_count = 0, check_count = 0, sc = 0;
  int usb_t[4] = '{40, 60, 30, 24};
  int sd_t[4] = '{60, 30, 15, 15};
  int pin_t[8] = '{0, 0, 0, 0, 60, 60, 60, 30};
  logic [31:0] q[$];
  ccp_clock_config DUT (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pll_enabled, .usb_device1_clk_en(usb1), .usb_device2_clk_en(usb2), .system_clock(src),
    .internal_rc_clock(src), .external_osc_clock(src), .pll_output_clock(src),
    .bus_clock(src), .memory_controller_clock(src), .cfg(), .pll_multiple, .usb_clock,
    .clock_output_pin, .fpu_clock, .sdram_clock);
  always #4 clk = ~clk;
  always @(posedge clk) begin
    sc <= (sc == 2) ? 0 : sc + 1;
    if (sc == 2) src <= ~src;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rate(input int got, input int exp);
    check_count++;
    if (got < exp - 2 || got > exp + 2) begin
      err_count++;
      $display("mismatch at %0t: toggles %0d expected %0d", $time, got, exp);
    end
  endtask
  // on a read, d doubles as the expected word; wdata is ignored then
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    if (r) q.push_back(d);
    @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rd_d) begin
      if (q.size() == 0) begin
        err_count++;
        $display("mismatch at %0t: read data with no expectation", $time);
      end else begin
        cmp(reg_rdata, q.pop_front());
      end
    end
    rd_d <= reg_rd;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict();
  end
  initial begin
    logic [12:0] v;
    logic [31:0] w;
    int tg[4];
    logic [3:0] pv;
    void'($urandom(51));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    // sources run at clk/6, far under every software rate limit
    bus(0, 1, 8'h04, 32'h0);
    for (int i = 0; i < 16; i++) begin
      v = {i[3:2], i[0], i[2:0], i[1:0], i[3:0], i[1]};
      w = $urandom;
      w[29:17] = v;
      bus(1, 0, 8'h04, w);
      bus(0, 1, 8'h04, {2'b00, v, 17'h0});
      cmp({27'h0, pll_multiple}, (i == 15) ? 32'd16 : i + 2);
      bus(0, 0, 8'h04, 32'h0);
      repeat (20) @(posedge clk);
      tg = '{0, 0, 0, 0};
      pv = outs;
      repeat (180) begin
        @(posedge clk);
        for (int j = 0; j < 4; j++) tg[j] += int'(outs[j] ^ pv[j]);
        pv = outs;
      end
      cmp_rate(tg[3], usb_t[i[1:0]]);
      cmp_rate(tg[2], i[0] ? 30 : 60);
      cmp_rate(tg[1], sd_t[i[3:2]]);
      cmp_rate(tg[0], pin_t[i[2:0]]);
    end
    pll_enabled <= 1'b1;
    bus(1, 0, 8'h04, 32'h0080_0000);
    bus(0, 1, 8'h04, {2'b00, 13'h05f, 17'h0});
    pll_enabled <= 1'b0;
    // usb divider already programmed before the usb enable rises
    usb1 <= 1'b1;
    bus(1, 0, 8'h04, 32'h004c_0000);
    bus(0, 1, 8'h04, {2'b00, 13'h066, 17'h0});
    usb1 <= 1'b0;
    usb2 <= 1'b1;
    bus(1, 0, 8'h04, 32'h0);
    usb2 <= 1'b0;
    bus(1, 0, 8'h08, 32'hffff_ffff);
    bus(0, 1, 8'h08, 32'h0);
    bus(0, 1, 8'h04, {2'b00, 13'h060, 17'h0});
    bus(1, 0, 8'h04, 32'h0);
    bus(0, 1, 8'h04, 32'h0);
    bus(0, 0, 8'h04, 32'h0);
    repeat (3) @(posedge clk);
    give_verdict();
  end
endmodule
